// file: logic/abrc_consts.svh
`ifndef ABRC_CONSTS_SVH
`define ABRC_CONSTS_SVH

// Register byte offsets
`define ABRC_OFS_STATUS1  8'h00
`define ABRC_OFS_CTRL1    8'h04
`define ABRC_OFS_BSET1    8'h08
`define ABRC_OFS_BCLR1    8'h0C
`define ABRC_OFS_BSET2    8'h10
`define ABRC_OFS_BCLR2    8'h14
`define ABRC_OFS_SSRESET  8'h18
`define ABRC_OFS_FCWIN    8'h1C
`define ABRC_OFS_EVCNT_LO 8'h20
`define ABRC_OFS_EVCNT_HI 8'h24
`define ABRC_OFS_INCR_EVT 8'h28
`define ABRC_OFS_STATUS2  8'h2C

// Field positions
`define ABRC_ST1_DATA_READY_LINE     0
`define ABRC_ST1_CHDRDY   1
`define ABRC_ST1_BUSY     2
`define ABRC_ST1_GBUSY    3
`define ABRC_ST2_EMPTY    1
`define ABRC_ST2_FULL     2
`define ABRC_CTL_PSCOPE   4
`define ABRC_BS1_SWRST    7
`define ABRC_BS2_MEMTEST  0
`define ABRC_BS2_CLRDATA  2
`define ABRC_BS2_ALLGATE  14

// Reset values
`define ABRC_RST_CTRL1    16'h0000
`define ABRC_RST_BSET1    16'h0000
`define ABRC_RST_BSET2    16'h4000
`define ABRC_RST_FCWIN    10'h000

// Timing
`define ABRC_CLK_NS       50
`define ABRC_CONV_NS      5700
`define ABRC_CONV_CYC     ((`ABRC_CONV_NS + `ABRC_CLK_NS - 1) / `ABRC_CLK_NS)
`define ABRC_FCGAP_NS     600
`define ABRC_FCGAP_CYC    ((`ABRC_FCGAP_NS + `ABRC_CLK_NS - 1) / `ABRC_CLK_NS)

`endif

// file: logic/abrc_pkg.sv
`default_nettype none

package abrc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_CLEAR
  } abrc_state_t;

  // Synchronised control-bus inputs
  typedef struct packed {
    logic data_ready_line;
    logic busy;
    logic rst;
    logic conversion_inhibit;
    logic fast_clear_input;
    logic gate;
  } abrc_ctl_t;

  typedef struct packed {
    abrc_state_t  st;
    logic [7:0]   cnt;
    logic [9:0]   win;
    logic [4:0]   wp;
    logic [4:0]   rp;
    logic         last_wr;
    logic [23:0]  evc;
    logic [15:0]  ctrl1;
    logic [15:0]  bs1;
    logic [15:0]  bs2;
    logic [9:0]   fcw;
    logic         wreq;
    logic [31:0]  rdata;
    logic         busy;
    logic         data_ready_line;
  } abrc_regs_t;

endpackage : abrc_pkg

`default_nettype wire

// file: logic/abrc_sync.sv
`timescale 1ns/100ps
`default_nettype none

module abrc_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Raw levels in, synchronised levels and rising edges out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise
);
  import abrc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } abrc_sync_t;

  abrc_sync_t s_q;
  abrc_sync_t s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Only the second and third stages are looked at; the first may be metastable
  assign lvl  = s_q.s2;
  assign rise = s_q.s2 & ~s_q.s3;

endmodule : abrc_sync

`default_nettype wire

// file: logic/abrc_top.sv
// Summary of operation
// - Busy during conversion, analogue reset, full event buffer or memory test mode.
// - Busy drives the bus busy line and status bits 2 and 3.
// - Busy rises after an accepted gate edge, falls at conversion end.
// - Gate pulses while busy start no conversion; they still reload the fast-clear window and count in all-gate mode.
// - Scope jumper selects halting on chain busy or local busy only.
// - Data reset clears buffer, pointers, event counter and peak sections; registers kept.
// - Set-2 data-clear bit holds data reset until cleared through clear-2.
// - Panel reset does data reset, or software reset when scope bit set.
// - Software reset adds return of software-resettable registers to defaults.
// - Set-1 software-reset bit holds reset until a clear-1 write releases it.
// - Single-shot register write resets for as long as the access lasts.
// - Hardware reset does all of that plus the remaining registers.
// - Fast clear inside the window aborts conversion and clears peaks; otherwise ignored.
// - After fast clear a gate is taken only 600 ns past its edge.
// - Panel reset clears peaks, buffer status and stops pending conversions.
// - Data ready while buffer holds an event; status bits 0 and 1.
// - Chained positive lines are wired OR, negative lines wired NAND.
// - No conversion starts while conversion_inhibit is asserted.
// - Gate is the OR of the bus gate and the shared gate input.
// - Only gates with conversion_inhibit, fast clear and busy idle are accepted.
// - Equal pointers mean full after a write step, empty after a read step.
`timescale 1ns/100ps
`default_nettype none

`include "abrc_consts.svh"

module abrc_top (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // Board setting
  input  wire logic        BUSY_SCOPE_JUMPER,
  // Control bus inputs
  input  wire logic        GATE,
  input  wire logic        GATE_COMMON,
  input  wire logic        CONVERSION_INHIBIT,
  input  wire logic        FAST_CLEAR_INPUT,
  input  wire logic        PANEL_RESET,
  // Chained busy line
  input  wire logic        BUSY_I,
  output logic             BUSY_O,
  output logic             BUSY_OE,
  // Chained data-ready line
  input  wire logic        DATA_READY_LINE_I,
  output logic             DATA_READY_LINE_O,
  output logic             DATA_READY_LINE_OE,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST
);
  import abrc_pkg::*;

  localparam logic [7:0] CONV_CYC = 8'(`ABRC_CONV_CYC);
  localparam logic [7:0] GAP_CYC  = 8'(`ABRC_FCGAP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  abrc_ctl_t raw;
  abrc_ctl_t lvl;
  abrc_ctl_t rise;

  always_comb begin
    raw      = '0;
    raw.gate = GATE | GATE_COMMON;
    raw.fast_clear_input = FAST_CLEAR_INPUT;
    raw.conversion_inhibit = CONVERSION_INHIBIT;
    raw.rst  = PANEL_RESET;
    raw.busy = BUSY_I;
    raw.data_ready_line = DATA_READY_LINE_I;
  end

  abrc_sync #(
    .W ($bits(abrc_ctl_t))
  ) u_sync (
    .clk  (MCLK),
    .rst  (RESET),
    .d    (raw),
    .lvl  (lvl),
    .rise (rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  abrc_regs_t s_q;
  abrc_regs_t s_d;

  logic        acc;
  logic        done;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic        ss_rst;
  logic        sw_rst;
  logic        dat_rst;
  logic        full;
  logic        empty;
  logic        busy;
  logic        stop;
  logic        gate_ok;
  logic        win_open;
  logic        conv_end;
  logic        rp_inc;
  logic [31:0] rd;

  always_comb begin
    s_d      = s_q;
    acc      = AVS_READ | AVS_WRITE;
    done     = acc & ~s_q.wreq;
    wmask    = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    wd       = AVS_WRITEDATA & wmask;

    // Held for the whole access, waitrequest phase included
    ss_rst   = AVS_WRITE & (AVS_ADDRESS == `ABRC_OFS_SSRESET);

    // Panel reset acts as a level, so a long pulse keeps it in force
    sw_rst   = s_q.bs1[`ABRC_BS1_SWRST]
             | ss_rst
             | (lvl.rst & s_q.ctrl1[`ABRC_CTL_PSCOPE]);
    dat_rst  = sw_rst
             | s_q.bs2[`ABRC_BS2_CLRDATA]
             | (lvl.rst & ~s_q.ctrl1[`ABRC_CTL_PSCOPE]);

    full     = (s_q.wp == s_q.rp) & s_q.last_wr;
    empty    = (s_q.wp == s_q.rp) & ~s_q.last_wr;

    busy     = (s_q.st != ST_IDLE)
             | full
             | s_q.bs2[`ABRC_BS2_MEMTEST]
             | dat_rst;

    // Chain-wide scope also stops on other boards' busy
    stop     = busy | (BUSY_SCOPE_JUMPER & lvl.busy);

    gate_ok  = rise.gate & ~lvl.conversion_inhibit & ~lvl.fast_clear_input & ~stop;
    win_open = (s_q.win != 10'h000);

    conv_end = 1'b0;
    rp_inc   = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // Read data

    rd = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      `ABRC_OFS_STATUS1: begin
        rd[`ABRC_ST1_DATA_READY_LINE]   = ~empty;
        rd[`ABRC_ST1_CHDRDY] = lvl.data_ready_line;
        rd[`ABRC_ST1_BUSY]   = busy;
        rd[`ABRC_ST1_GBUSY]  = busy | lvl.busy;
      end
      `ABRC_OFS_STATUS2: begin
        rd[`ABRC_ST2_EMPTY] = empty;
        rd[`ABRC_ST2_FULL]  = full;
      end
      `ABRC_OFS_CTRL1:    rd[15:0] = s_q.ctrl1;
      `ABRC_OFS_BSET1,
      `ABRC_OFS_BCLR1:    rd[15:0] = s_q.bs1;
      `ABRC_OFS_BSET2,
      `ABRC_OFS_BCLR2:    rd[15:0] = s_q.bs2;
      `ABRC_OFS_FCWIN:    rd[9:0]  = s_q.fcw;
      `ABRC_OFS_EVCNT_LO: rd[15:0] = s_q.evc[15:0];
      `ABRC_OFS_EVCNT_HI: rd[7:0]  = s_q.evc[23:16];
      default:            rd = 32'h0000_0000;
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then a one-cycle answer

    if (acc && s_q.wreq) begin
      s_d.wreq  = 1'b0;
      s_d.rdata = AVS_READ ? rd : 32'h0000_0000;
    end else begin
      s_d.wreq  = 1'b1;
    end

    if (done && AVS_WRITE) begin
      unique case (AVS_ADDRESS)
        `ABRC_OFS_CTRL1: s_d.ctrl1 = (s_q.ctrl1 & ~wmask[15:0]) | wd[15:0];
        `ABRC_OFS_BSET1: s_d.bs1   = s_q.bs1 | wd[15:0];
        `ABRC_OFS_BCLR1: s_d.bs1   = s_q.bs1 & ~wd[15:0];
        `ABRC_OFS_BSET2: s_d.bs2   = s_q.bs2 | wd[15:0];
        `ABRC_OFS_BCLR2: s_d.bs2   = s_q.bs2 & ~wd[15:0];
        `ABRC_OFS_FCWIN: s_d.fcw   = (s_q.fcw & ~wmask[9:0]) | wd[9:0];
        `ABRC_OFS_INCR_EVT: rp_inc = ~empty;
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Fast-clear window, opened by any gate leading edge

    if (rise.gate) begin
      s_d.win = s_q.fcw;
    end else if (win_open) begin
      s_d.win = s_q.win - 10'h001;
    end

    //////////////////////////////////////////////////////////////////////////
    // Conversion sequence

    unique case (s_q.st)
      ST_IDLE: begin
        if (gate_ok) begin
          s_d.st  = ST_CONV;
          s_d.cnt = CONV_CYC;
        end
      end
      ST_CONV: begin
        // A clear outside the window is simply not seen here
        if (rise.fast_clear_input && win_open) begin
          s_d.st  = ST_CLEAR;
          s_d.cnt = GAP_CYC;
        end else if (s_q.cnt == 8'h01) begin
          s_d.st   = ST_IDLE;
          conv_end = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      ST_CLEAR: begin
        // Busy keeps gates out until the clear cycle is over
        if (s_q.cnt == 8'h01) begin
          s_d.st = ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      default: begin
        // Unused code; fall back to idle rather than lock up busy
        s_d.st = ST_IDLE;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Event buffer pointers

    if (conv_end && !rp_inc) begin
      s_d.wp      = s_q.wp + 5'h01;
      s_d.last_wr = 1'b1;
    end else if (rp_inc && !conv_end) begin
      s_d.rp      = s_q.rp + 5'h01;
      s_d.last_wr = 1'b0;
    end else if (rp_inc && conv_end) begin
      s_d.wp = s_q.wp + 5'h01;
      s_d.rp = s_q.rp + 5'h01;
    end

    //////////////////////////////////////////////////////////////////////////
    // Event counter

    if (s_q.bs2[`ABRC_BS2_ALLGATE] ? rise.gate : gate_ok) begin
      s_d.evc = s_q.evc + 24'h00_0001;
    end

    //////////////////////////////////////////////////////////////////////////
    // Resets; the data part never touches the registers

    if (dat_rst) begin
      s_d.st      = ST_IDLE;
      s_d.cnt     = 8'h00;
      s_d.win     = 10'h000;
      s_d.wp      = 5'h00;
      s_d.rp      = 5'h00;
      s_d.last_wr = 1'b0;
      s_d.evc     = 24'h00_0000;
    end
    // The set-1 bit survives so that only its clear write ends the reset
    if (sw_rst) begin
      s_d.ctrl1 = `ABRC_RST_CTRL1;
      s_d.bs2   = `ABRC_RST_BSET2;
    end

    //////////////////////////////////////////////////////////////////////////
    // Registered outputs

    s_d.busy = busy;
    s_d.data_ready_line = ~empty;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; RESET is the hardware reset of every field

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.ctrl1   <= `ABRC_RST_CTRL1;
      s_q.bs1     <= `ABRC_RST_BSET1;
      s_q.bs2     <= `ABRC_RST_BSET2;
      s_q.fcw     <= `ABRC_RST_FCWIN;
      s_q.wreq    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; lines are only pulled while active so boards wire-OR

  assign BUSY_O             = s_q.busy;
  assign BUSY_OE            = s_q.busy;
  assign DATA_READY_LINE_O  = s_q.data_ready_line;
  assign DATA_READY_LINE_OE = s_q.data_ready_line;
  assign AVS_READDATA       = s_q.rdata;
  assign AVS_WAITREQUEST    = s_q.wreq;

endmodule : abrc_top

`default_nettype wire

// file: dv/abrc_top_checker.sv
`timescale 1ns/100ps
`default_nettype none

module abrc_top_checker (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // Control bus
  input wire logic GATE,
  input wire logic GATE_COMMON,
  input wire logic CONVERSION_INHIBIT,
  input wire logic FAST_CLEAR_INPUT,
  input wire logic PANEL_RESET,
  input wire logic BUSY_I,
  input wire logic BUSY_O,
  input wire logic BUSY_OE,
  input wire logic DATA_READY_LINE_O,
  input wire logic DATA_READY_LINE_OE,
  // Register bus
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////
  // Gate edge with every stop line idle
  sequence s_gate_ok;
    $rose(GATE) && !GATE_COMMON && !BUSY_O && !BUSY_I && !CONVERSION_INHIBIT
      && !FAST_CLEAR_INPUT && !PANEL_RESET && !AVS_WRITE;
  endsequence
  sequence s_conv;
    BUSY_O [*8];
  endsequence
  // Eight cycles of inhibit cover the input synchroniser delay
  sequence s_inhibit;
    (CONVERSION_INHIBIT && !AVS_WRITE && !PANEL_RESET) [*8];
  endsequence
  property p_gate_busy;
    s_gate_ok |-> ##[1:6] s_conv;
  endproperty
  property p_conversion_inhibit;
    s_inhibit |-> !$rose(BUSY_O);
  endproperty
  property p_busy_oe;
    BUSY_OE == BUSY_O;
  endproperty
  property p_data_ready_line_oe;
    DATA_READY_LINE_OE == DATA_READY_LINE_O;
  endproperty
  property p_panel;
    PANEL_RESET [*7] |-> BUSY_O && !DATA_READY_LINE_O;
  endproperty
  // Writes and panel reset act a few cycles late, so their recent past is excluded too
  property p_data_ready_line_keep;
    DATA_READY_LINE_O && !AVS_WRITE && !$past(AVS_WRITE) && !$past(AVS_WRITE, 2)
      && !PANEL_RESET && !$past(PANEL_RESET) && !$past(PANEL_RESET, 2) && !$past(PANEL_RESET, 3)
      |=> DATA_READY_LINE_O;
  endproperty
  property p_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  property p_wait_one;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_gate_busy: assert property (p_gate_busy) else $error("busy missing after gate");
  a_conversion_inhibit: assert property (p_conversion_inhibit) else $error("busy rose under conversion_inhibit");
  a_busy_oe: assert property (p_busy_oe) else $error("busy enable differs");
  a_data_ready_line_oe: assert property (p_data_ready_line_oe) else $error("ready enable differs");
  a_panel: assert property (p_panel) else $error("panel reset not applied");
  a_data_ready_line_keep: assert property (p_data_ready_line_keep) else $error("data ready dropped");
  a_wait: assert property (p_wait) else $error("no answer next cycle");
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
endmodule : abrc_top_checker

`default_nettype wire

// file: dv/abrc_trigger_model.sv
`timescale 1ns/100ps
`default_nettype none

module abrc_trigger_model (
  // Clock
  input  wire logic clk,
  // Board drive and other boards
  input  wire logic busy_o,
  input  wire logic busy_oe,
  input  wire logic data_ready_line_o,
  input  wire logic data_ready_line_oe,
  input  wire logic other_busy,
  input  wire logic other_data_ready_line,
  // Lines towards the board
  output var logic  gate,
  output var logic  fast_clear_input,
  output logic      busy_i,
  output logic      data_ready_line_i
);
  initial begin
    gate = 1'b0;
    fast_clear_input = 1'b0;
  end
  // Wired OR of all boards on the positive lines
  assign busy_i = (busy_o & busy_oe) | other_busy;
  assign data_ready_line_i = (data_ready_line_o & data_ready_line_oe) | other_data_ready_line;
  ////////////////////////////////////////
  // 300 ns keeps clear of the minimum width
  task automatic gate_pulse;
    @(posedge clk);
    gate <= 1'b1;
    repeat (6) @(posedge clk);
    gate <= 1'b0;
  endtask : gate_pulse
  // Spacing after the pulse keeps the next gate 600 ns away
  task automatic fast_clear_input_pulse;
    @(posedge clk);
    fast_clear_input <= 1'b1;
    repeat (2) @(posedge clk);
    fast_clear_input <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : fast_clear_input_pulse
endmodule : abrc_trigger_model

`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        mclk, reset, jumper, gate, gate_common, conversion_inhibit, fast_clear_input, panel;
  logic        busy_i, busy_o, busy_oe, data_ready_line_i, data_ready_line_o, data_ready_line_oe, other_busy, other_data_ready_line;
  logic        avs_read, avs_write, avs_wait;
  logic [7:0]  avs_addr;
  logic [3:0]  avs_be;
  logic [31:0] avs_wdata, avs_rdata;
  int          bad_count, checked;
  logic [39:0] rows [9] = '{40'h00_0000_0000, 40'h04_0000_0000, 40'h08_0000_0000, 40'h10_0000_4000,
    40'h1C_0000_0000, 40'h20_0000_0000, 40'h24_0000_0000, 40'h2C_0000_0002, 40'h30_0000_0000};

  abrc_top abrc_top_i (.MCLK(mclk), .RESET(reset), .BUSY_SCOPE_JUMPER(jumper), .GATE(gate),
    .GATE_COMMON(gate_common), .CONVERSION_INHIBIT(conversion_inhibit), .FAST_CLEAR_INPUT(fast_clear_input), .PANEL_RESET(panel),
    .BUSY_I(busy_i), .BUSY_O(busy_o), .BUSY_OE(busy_oe), .DATA_READY_LINE_I(data_ready_line_i),
    .DATA_READY_LINE_O(data_ready_line_o), .DATA_READY_LINE_OE(data_ready_line_oe), .AVS_ADDRESS(avs_addr),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_wdata), .AVS_BYTEENABLE(avs_be),
    .AVS_READDATA(avs_rdata), .AVS_WAITREQUEST(avs_wait));
  abrc_trigger_model trig_i (.clk(mclk), .busy_o(busy_o), .busy_oe(busy_oe), .data_ready_line_o(data_ready_line_o),
    .data_ready_line_oe(data_ready_line_oe), .other_busy(other_busy), .other_data_ready_line(other_data_ready_line), .gate(gate), .fast_clear_input(fast_clear_input),
    .busy_i(busy_i), .data_ready_line_i(data_ready_line_i));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_addr <= a;
    avs_wdata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_wait !== 1'b0);
    q = avs_rdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rdc
  task automatic wbusy(input logic v);
    int n;
    n = 0;
    while (busy_o !== v && n < 400) begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0000_0000, busy_o}, {31'h0000_0000, v});
  endtask : wbusy
  task automatic pnl;
    panel <= 1'b1;
    repeat (8) @(posedge mclk);
    panel <= 1'b0;
    wbusy(1'b0);
  endtask : pnl
  task automatic reset_rows;
    for (int i = 0; i < 9; i++) rdc(rows[i][39:32], rows[i][31:0]);
    note("reset values");
  endtask : reset_rows
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Whole sequence needs about 5000 cycles
  initial begin
    #(12000 * 50);
    bad_count++;
    give_verdict();
  end
  initial begin
    {reset, jumper, gate_common, conversion_inhibit, panel, other_busy, other_data_ready_line} = 7'h40;
    {avs_read, avs_write, avs_addr, avs_wdata, avs_be} = {42'h000_0000_0000, 4'hF};
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    reset_rows();
    trig_i.gate_pulse();
    rdc(8'h00, 32'h0000_000C);
    wbusy(1'b0);
    chk({31'h0000_0000, data_ready_line_o}, 32'h0000_0001);
    rdc(8'h20, 32'h0000_0001);
    rdc(8'h00, 32'h0000_0003);
    trig_i.gate_pulse();
    trig_i.gate_pulse();
    wbusy(1'b0);
    rdc(8'h20, 32'h0000_0003);
    wr(8'h28, 32'h0000_0000);
    rdc(8'h2C, 32'h0000_0000);
    wr(8'h28, 32'h0000_0000);
    rdc(8'h2C, 32'h0000_0002);
    note("gate and busy");
    wr(8'h14, 32'h0000_4000);
    conversion_inhibit <= 1'b1;
    repeat (8) @(posedge mclk);
    trig_i.gate_pulse();
    conversion_inhibit <= 1'b0;
    chk({31'h0000_0000, busy_o}, 32'h0000_0000);
    rdc(8'h20, 32'h0000_0003);
    note("conversion_inhibit");
    wr(8'h1C, 32'h0000_0014);
    trig_i.gate_pulse();
    trig_i.fast_clear_input_pulse();
    wbusy(1'b0);
    rdc(8'h2C, 32'h0000_0002);
    wr(8'h1C, 32'h0000_0000);
    trig_i.gate_pulse();
    trig_i.fast_clear_input_pulse();
    wbusy(1'b0);
    rdc(8'h2C, 32'h0000_0000);
    wr(8'h28, 32'h0000_0000);
    note("fast clear");
    {other_busy, other_data_ready_line, jumper} <= 3'h7;
    repeat (4) @(posedge mclk);
    rdc(8'h00, 32'h0000_000A);
    trig_i.gate_pulse();
    chk({31'h0000_0000, busy_o}, 32'h0000_0000);
    jumper <= 1'b0;
    // Let the gate line settle low first, or the OR would show no new edge
    repeat (2) @(posedge mclk);
    gate_common <= 1'b1;
    repeat (6) @(posedge mclk);
    gate_common <= 1'b0;
    wbusy(1'b1);
    wbusy(1'b0);
    {other_busy, other_data_ready_line} <= 2'h0;
    wr(8'h28, 32'h0000_0000);
    note("busy scope");
    wr(8'h1C, 32'h0000_0007);
    wr(8'h10, 32'h0000_0004);
    wbusy(1'b1);
    rdc(8'h20, 32'h0000_0000);
    rdc(8'h1C, 32'h0000_0007);
    wr(8'h14, 32'h0000_0004);
    wbusy(1'b0);
    wr(8'h04, 32'h0000_0010);
    wr(8'h08, 32'h0000_0080);
    repeat (20) @(posedge mclk);
    wbusy(1'b1);
    rdc(8'h04, 32'h0000_0000);
    rdc(8'h10, 32'h0000_4000);
    rdc(8'h1C, 32'h0000_0007);
    wr(8'h0C, 32'h0000_0080);
    wbusy(1'b0);
    wr(8'h04, 32'h0000_0010);
    wr(8'h18, 32'h0000_0000);
    rdc(8'h04, 32'h0000_0000);
    wr(8'h04, 32'h0000_0010);
    pnl();
    rdc(8'h04, 32'h0000_0000);
    wr(8'h14, 32'h0000_4000);
    pnl();
    rdc(8'h10, 32'h0000_0000);
    note("resets");
    wr(8'h10, 32'h0000_0001);
    wbusy(1'b1);
    wr(8'h14, 32'h0000_0001);
    wbusy(1'b0);
    for (int i = 0; i < 32; i++) begin
      trig_i.gate_pulse();
      repeat (125) @(posedge mclk);
    end
    chk({31'h0000_0000, busy_o}, 32'h0000_0001);
    rdc(8'h2C, 32'h0000_0004);
    wr(8'h28, 32'h0000_0000);
    wbusy(1'b0);
    note("full buffer");
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    reset_rows();
    give_verdict();
  end
endmodule : testbench

bind abrc_top abrc_top_checker chk_i (.MCLK(MCLK), .RESET(RESET), .GATE(GATE), .GATE_COMMON(GATE_COMMON),
  .CONVERSION_INHIBIT(CONVERSION_INHIBIT), .FAST_CLEAR_INPUT(FAST_CLEAR_INPUT), .PANEL_RESET(PANEL_RESET),
  .BUSY_I(BUSY_I), .BUSY_O(BUSY_O), .BUSY_OE(BUSY_OE), .DATA_READY_LINE_O(DATA_READY_LINE_O),
  .DATA_READY_LINE_OE(DATA_READY_LINE_OE), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST));

`default_nettype wire
